// [csp_pkg.sv]
// Constants, encodings and register map of the socket supply and clock block
// Assumes a 32-bit Avalon-MM register bus addressed in bytes
//
// Operation
// - Power socket only at card-acceptable voltages
// - Policy 0: halt only with host stopping
// - Policy 1: halt whenever socket idle and card not accessed
// - Card supply codes: off,5V,3.3V,X,Y
// - Program supply codes: off,12V,5V,3.3V,X,Y
// - Control bits 31-8 and 3 read zero
// - Access flag set by any card access
// - Reading power register clears access flag
// - Clock mode flag shows stopped/slowed clock
// - Stop/slow select needs policy enable set
// - Select 0 lets clock stop when idle
// - Select 1 slows clock by sixteen
// - Power register reserved bits read zero
// - Forced card-type bits disable supply control
// - Retest write re-enables supply control

package csp_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int          ADDR_W          = 8;
  localparam logic [7:0]  OFS_FORCE       = 8'h0C; // Force event
  localparam logic [7:0]  OFS_SUPPLY_CTL  = 8'h10; // Supply and policy
  localparam logic [7:0]  OFS_POWER_MGMT  = 8'h20; // Clock power mgmt
  localparam logic [7:0]  OFS_IRQ_STATUS  = 8'h30; // Sticky events
  localparam logic [7:0]  OFS_IRQ_MASK    = 8'h34; // Event mask

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_HALT_POLICY   = 7;  // Clock halt policy
  localparam int BIT_CARD_SUP_LO   = 4;  // Card supply field low bit
  localparam int BIT_PROG_SUP_LO   = 0;  // Program supply field low bit
  localparam int BIT_ACCESS_SEEN   = 25; // Card access seen
  localparam int BIT_CLK_CHANGED   = 24; // Clock changed flag
  localparam int BIT_POLICY_EN     = 16; // Clock policy enable
  localparam int BIT_STOP_OR_SLOW  = 0;  // Stop or slow select
  localparam int BIT_RETEST        = 14; // Voltage sense retest
  localparam int BIT_FORCED_HI     = 13; // Forced type bits high end
  localparam int BIT_FORCED_LO     = 10; // Forced type bits low end
  localparam int IRQ_W             = 2;  // Event count
  localparam int IRQ_ACCESS        = 0;  // Event: card access
  localparam int IRQ_CLK_CHANGE    = 1;  // Event: clock left normal

  // ****************************************************************
  // Supply encodings and reset values
  // ****************************************************************
  localparam logic [2:0]  SUP_OFF   = 3'h0;
  localparam logic [2:0]  SUP_12V   = 3'h1; // Program supply only
  localparam logic [2:0]  SUP_5V    = 3'h2;
  localparam logic [2:0]  SUP_3V3   = 3'h3;
  localparam logic [2:0]  SUP_XV    = 3'h4;
  localparam logic [2:0]  SUP_YV    = 3'h5;
  localparam int          CAPS_W    = 5;    // 12V,5V,3V3,X,Y support
  localparam logic [31:0] RST_REG   = 32'h0000_0000;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int          SLOW_DIV  = 16;   // Slow clock divider
  localparam int          DIV_W     = $clog2(SLOW_DIV);

  // Card clock states
  typedef enum logic [1:0] {
    CSP_CLK_RUN  = 2'b00,
    CSP_CLK_STOP = 2'b01,
    CSP_CLK_SLOW = 2'b10
  } csp_clk_e;

endpackage : csp_pkg

// [csp_supply_if.sv]
// Carries one supply request to its decoder and the granted code back
// Assumes both ends share the block clock; purely combinational
`timescale 1ns/1ps
`default_nettype none

interface csp_supply_if;
  logic [2:0] request; // Code as written by software
  logic       enable;  // Supply control register enabled
  logic [4:0] caps;    // Voltages the card accepts
  logic [2:0] grant;   // Code to act on

  modport ctl (output request, output enable, output caps, input grant);
  modport dec (input request, input enable, input caps, output grant);
endinterface : csp_supply_if

`default_nettype wire

// [csp_supply_decode.sv]
// Checks one supply request against encoding and card capability
// Assumes caps bit order 12V,5V,3V3,X,Y from bit 0 upward
`timescale 1ns/1ps
`default_nettype none

module csp_supply_decode
  import csp_pkg::*;
#(
  parameter bit ALLOW_12V = 1'b0 // Program supply knows the 12V code
) (
  csp_supply_if.dec sup
);

  logic ok; // Request legal and accepted by card

  // ****************************************************************
  // Decode
  // ****************************************************************
  // Reserved codes and unsupported voltages fall back to off
  always_comb begin
    case (sup.request)
      SUP_12V: ok = ALLOW_12V & sup.caps[0];
      SUP_5V:  ok = sup.caps[1];
      SUP_3V3: ok = sup.caps[2];
      SUP_XV:  ok = sup.caps[3];
      SUP_YV:  ok = sup.caps[4];
      default: ok = 1'b0;
    endcase
  end

  // Refused or disabled requests grant off
  assign sup.grant = (ok && sup.enable) ? sup.request : SUP_OFF;

endmodule : csp_supply_decode

`default_nettype wire

// [csp_socket_ctl.sv]
// Socket supply request and card clock-run policy with its registers
// Assumes an Avalon-MM master on mclk_i and synchronous socket inputs
`timescale 1ns/1ps
`default_nettype none

module csp_socket_ctl
  import csp_pkg::*;
(
  input  wire logic              mclk_i,          // Block clock
  input  wire logic              arst_n_i,        // Async reset
  input  wire logic              ce_i,            // Clock enable
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] address_i,       // Byte address
  input  wire logic              read_i,          // Read request
  input  wire logic              write_i,         // Write request
  input  wire logic [31:0]       writedata_i,     // Write data
  input  wire logic [3:0]        byteenable_i,    // Byte lanes
  output logic      [31:0]       readdata_o,      // Read data
  output logic                   waitrequest_o,   // Stall
  // Socket side
  input  wire logic              socket_idle_i,   // Socket has no work
  input  wire logic              host_clk_stop_i, // Host clock stopping
  input  wire logic              card_access_i,   // Card accessed
  input  wire logic [CAPS_W-1:0] card_caps_i,     // Accepted voltages
  output logic      [2:0]        card_supply_o,   // Granted card supply
  output logic      [2:0]        prog_supply_o,   // Granted prog supply
  output logic                   card_clk_en_o,   // Card clock enable
  output logic                   clock_changed_o, // Clock stopped/slowed
  output logic                   retest_o,        // Retest pulse
  output logic                   irq_o            // Level interrupt
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic              ack_q;          // Answer cycle of a bus request
  logic [31:0]       rdata_q;        // Registered read data
  logic              req;            // Bus request present
  logic              acc_wr;         // Write accepted this edge
  logic              acc_rd;         // Read accepted this edge
  logic              halt_policy_q;  // Clock halt policy bit
  logic [2:0]        card_req_q;     // Card supply request field
  logic [2:0]        prog_req_q;     // Program supply request field
  logic              sup_enable_q;   // Supply control register enabled
  logic              policy_en_q;    // Clock policy enable
  logic              stop_slow_q;    // Stop or slow select
  logic              access_seen_q;  // Card access seen
  logic              access_seen_d;  // Next access flag
  logic [IRQ_W-1:0]  irq_status_q;   // Sticky events
  logic [IRQ_W-1:0]  irq_mask_q;     // Event mask
  logic [IRQ_W-1:0]  irq_events;     // Events this cycle
  logic [IRQ_W-1:0]  irq_w1c;        // Bits cleared by write
  csp_clk_e          clk_state_q;    // Card clock state
  csp_clk_e          clk_state_d;    // Next card clock state
  logic [DIV_W-1:0]  div_q;          // Slow clock divider
  logic              may_halt;       // Clock-run may act
  logic [31:0]       rd_mux;         // Read data source

  csp_supply_if card_sup ();         // Card supply decode path
  csp_supply_if prog_sup ();         // Program supply decode path

  // ****************************************************************
  // Bus handshake
  // ****************************************************************
  // One wait cycle per request; frozen clock keeps the stall
  assign req           = read_i | write_i;
  assign waitrequest_o = req & ~(ack_q & ce_i);
  assign acc_wr        = write_i & ack_q & ce_i;
  assign acc_rd        = read_i & ack_q & ce_i;

  // Answer strobe toggles through each request
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ack_q <= 1'b0;
    end else if (ce_i) begin
      ack_q <= req & ~ack_q;
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  // Reserved bits and unmapped offsets read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (address_i)
      OFS_SUPPLY_CTL: begin
        rd_mux[BIT_HALT_POLICY]                   = halt_policy_q;
        rd_mux[BIT_CARD_SUP_LO+2:BIT_CARD_SUP_LO] = card_req_q;
        rd_mux[BIT_PROG_SUP_LO+2:BIT_PROG_SUP_LO] = prog_req_q;
      end
      OFS_POWER_MGMT: begin
        rd_mux[BIT_ACCESS_SEEN]  = access_seen_q;
        rd_mux[BIT_CLK_CHANGED]  = clock_changed_o;
        rd_mux[BIT_POLICY_EN]    = policy_en_q;
        rd_mux[BIT_STOP_OR_SLOW] = stop_slow_q;
      end
      OFS_IRQ_STATUS: rd_mux[IRQ_W-1:0] = irq_status_q;
      OFS_IRQ_MASK:   rd_mux[IRQ_W-1:0] = irq_mask_q;
      default:        rd_mux = 32'h0000_0000;       // Force reg reads 0
    endcase
  end

  // Data captured in the wait cycle, shown at acceptance
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= RST_REG;
    end else if (ce_i && read_i && !ack_q) begin
      rdata_q <= rd_mux;
    end
  end
  assign readdata_o = rdata_q;

  // ****************************************************************
  // Supply and policy register
  // ****************************************************************
  // Only the low byte holds writable fields
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      halt_policy_q <= 1'b0;
      card_req_q    <= SUP_OFF;
      prog_req_q    <= SUP_OFF;
    end else if (acc_wr && address_i == OFS_SUPPLY_CTL
                 && byteenable_i[0]) begin
      halt_policy_q <= writedata_i[BIT_HALT_POLICY];
      card_req_q    <= writedata_i[BIT_CARD_SUP_LO+2:BIT_CARD_SUP_LO];
      prog_req_q    <= writedata_i[BIT_PROG_SUP_LO+2:BIT_PROG_SUP_LO];
    end
  end

  // ****************************************************************
  // Force event register
  // ****************************************************************
  // Forced card type disables supply control, retest restores it
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sup_enable_q <= 1'b1;
    end else if (acc_wr && address_i == OFS_FORCE) begin
      if (byteenable_i[1] && writedata_i[BIT_RETEST]) begin
        sup_enable_q <= 1'b1;
      end else if (byteenable_i[1] &&
                   |writedata_i[BIT_FORCED_HI:BIT_FORCED_LO]) begin
        sup_enable_q <= 1'b0;
      end
    end
  end

  // Retest pulse asks the sense logic to interrogate the card
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      retest_o <= 1'b0;
    end else if (ce_i) begin
      retest_o <= acc_wr && address_i == OFS_FORCE && byteenable_i[1]
                  && writedata_i[BIT_RETEST];
    end
  end

  // ****************************************************************
  // Supply decode
  // ****************************************************************
  // Both supplies checked against the card's accepted voltages
  assign card_sup.request = card_req_q;
  assign card_sup.enable  = sup_enable_q;
  assign card_sup.caps    = card_caps_i;
  assign prog_sup.request = prog_req_q;
  assign prog_sup.enable  = sup_enable_q;
  assign prog_sup.caps    = card_caps_i;

  csp_supply_decode #(
    .ALLOW_12V (1'b0)
  ) u_card_dec (
    .sup (card_sup.dec)
  );

  csp_supply_decode #(
    .ALLOW_12V (1'b1)
  ) u_prog_dec (
    .sup (prog_sup.dec)
  );

  // Granted codes drive the switch from flops
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      card_supply_o <= SUP_OFF;
      prog_supply_o <= SUP_OFF;
    end else if (ce_i) begin
      card_supply_o <= card_sup.grant;
      prog_supply_o <= prog_sup.grant;
    end
  end

  // ****************************************************************
  // Power management register
  // ****************************************************************
  // Enable in byte 2, select in byte 0
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      policy_en_q <= 1'b0;
      stop_slow_q <= 1'b0;
    end else if (acc_wr && address_i == OFS_POWER_MGMT) begin
      if (byteenable_i[2]) begin
        policy_en_q <= writedata_i[BIT_POLICY_EN];
      end
      if (byteenable_i[0]) begin
        stop_slow_q <= writedata_i[BIT_STOP_OR_SLOW];
      end
    end
  end

  // ****************************************************************
  // Card access flag
  // ****************************************************************
  // Read clears only what it returned; a new access always wins
  always_comb begin
    access_seen_d = access_seen_q;
    if (acc_rd && address_i == OFS_POWER_MGMT
        && rdata_q[BIT_ACCESS_SEEN]) begin
      access_seen_d = 1'b0;
    end
    if (card_access_i) begin
      access_seen_d = 1'b1;
    end
  end

  // Flag register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      access_seen_q <= 1'b0;
    end else if (ce_i) begin
      access_seen_q <= access_seen_d;
    end
  end

  // ****************************************************************
  // Card clock-run
  // ****************************************************************
  // Policy 1 needs idle with no card access; policy 0 also needs host stopping
  assign may_halt = policy_en_q && socket_idle_i && !card_access_i
                    && (halt_policy_q || host_clk_stop_i);

  // Next clock state
  always_comb begin
    clk_state_d = clk_state_q;
    case (clk_state_q)
      CSP_CLK_RUN: begin
        if (may_halt) begin
          clk_state_d = stop_slow_q ? CSP_CLK_SLOW
                                    : CSP_CLK_STOP;
        end
      end
      CSP_CLK_STOP, CSP_CLK_SLOW: begin
        if (!may_halt) begin                        // Wake on activity
          clk_state_d = CSP_CLK_RUN;
        end
      end
      default: clk_state_d = CSP_CLK_RUN;
    endcase
  end

  // State register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clk_state_q <= CSP_CLK_RUN;
    end else if (ce_i) begin
      clk_state_q <= clk_state_d;
    end
  end

  // Divider for the slowed clock
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      div_q <= '0;
    end else if (ce_i) begin
      div_q <= (clk_state_d == CSP_CLK_SLOW) ? div_q + 1'b1 : '0;
    end
  end

  // Clock enable and mode flag from flops
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      card_clk_en_o   <= 1'b1;
      clock_changed_o <= 1'b0;
    end else if (ce_i) begin
      case (clk_state_d)
        CSP_CLK_STOP: card_clk_en_o <= 1'b0;
        CSP_CLK_SLOW: card_clk_en_o <= (div_q == '0);
        default:      card_clk_en_o <= 1'b1;
      endcase
      clock_changed_o <= (clk_state_d != CSP_CLK_RUN);
    end
  end

  // ****************************************************************
  // Interrupts
  // ****************************************************************
  assign irq_events[IRQ_ACCESS]     = card_access_i;
  assign irq_events[IRQ_CLK_CHANGE] = (clk_state_q == CSP_CLK_RUN)
                                      && (clk_state_d != CSP_CLK_RUN);
  assign irq_w1c = (acc_wr && address_i == OFS_IRQ_STATUS
                    && byteenable_i[0]) ? writedata_i[IRQ_W-1:0] : '0;

  // Sticky status, a new event beats the clear
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_status_q <= '0;
    end else if (ce_i) begin
      irq_status_q <= (irq_status_q & ~irq_w1c) | irq_events;
    end
  end

  // Mask register
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_mask_q <= '0;
    end else if (acc_wr && address_i == OFS_IRQ_MASK && byteenable_i[0]) begin
      irq_mask_q <= writedata_i[IRQ_W-1:0];
    end
  end

  // Level interrupt
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |((irq_status_q & ~irq_w1c | irq_events) & irq_mask_q);
    end
  end

endmodule : csp_socket_ctl

`default_nettype wire

// [csp_card_model.sv]
// Card-side stand-in: drives idle, access and voltage capability
// Assumes the bench commands it on the block clock
`timescale 1ns/1ps
`default_nettype none
module csp_card_model (
  input  wire logic       mclk_i,   // Block clock
  input  wire logic       arst_n_i, // Async reset
  input  wire logic       busy_i,   // Card has work pending
  input  wire logic       poke_i,   // Card is being accessed
  input  wire logic [4:0] caps_i,   // Voltages the card takes
  output logic            idle_o,   // Socket idle
  output logic            access_o, // Access seen this cycle
  output logic      [4:0] caps_o    // Advertised voltages
);
  // Registered like real card pins, so every change lags one cycle
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      idle_o   <= 1'b1;
      access_o <= 1'b0;
      caps_o   <= 5'h1F;
    end else begin
      idle_o   <= ~busy_i & ~poke_i;
      access_o <= poke_i;
      caps_o   <= caps_i;
    end
  end
endmodule : csp_card_model
`default_nettype wire

// [csp_socket_ctl_chk.sv]
// Port checker for the socket supply and clock block
// Assumes it is bound into csp_socket_ctl; one clock domain
`timescale 1ns/1ps
`default_nettype none
module csp_socket_ctl_chk
  import csp_pkg::*;
(
  input wire logic              mclk_i,
  input wire logic              arst_n_i,
  input wire logic              ce_i,
  input wire logic [ADDR_W-1:0] address_i,
  input wire logic              read_i,
  input wire logic              write_i,
  input wire logic [31:0]       writedata_i,
  input wire logic [3:0]        byteenable_i,
  input wire logic [31:0]       readdata_o,
  input wire logic              waitrequest_o,
  input wire logic              socket_idle_i,
  input wire logic              card_access_i,
  input wire logic [CAPS_W-1:0] card_caps_i,
  input wire logic [2:0]        card_supply_o,
  input wire logic [2:0]        prog_supply_o,
  input wire logic              card_clk_en_o,
  input wire logic              clock_changed_o,
  input wire logic              retest_o
);
  // ******
  // Helper logic
  // ******
  logic [CAPS_W-1:0] caps_q; // Caps one cycle ago
  logic [4:0]        gap_q;  // Run of low clock enable cycles
  logic              tkn;    // Bus request taken
  assign tkn = (read_i | write_i) & ~waitrequest_o & ce_i;
  // Delayed caps and saturating gap count
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      caps_q <= '0;
      gap_q  <= '0;
    end else begin
      caps_q <= card_caps_i;
      gap_q  <= card_clk_en_o ? 5'h00 : gap_q + {4'h0, gap_q != 5'h1F};
    end
  end
  // ******
  // Assertions
  // ******
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);
  sequence s_new_req;
    ce_i && (read_i || write_i) && !$past(read_i || write_i);
  endsequence
  sequence s_one_wait;
    waitrequest_o ##1 !waitrequest_o;
  endsequence
  chk_bus_wait: assert property (s_new_req |-> s_one_wait)
    else $error("bus answer not after one wait cycle");
  chk_ctl_zero: assert property (
    tkn && read_i && address_i == OFS_SUPPLY_CTL
    |-> readdata_o[31:8] == '0 && !readdata_o[3])
    else $error("control reserved bits not zero");
  chk_pwr_zero: assert property (
    tkn && read_i && address_i == OFS_POWER_MGMT
    |-> (readdata_o & 32'hFCFE_FFFE) == '0)
    else $error("power reserved bits not zero");
  chk_card_grant: assert property (
    card_supply_o != SUP_OFF |-> card_supply_o != SUP_12V
    && card_supply_o <= SUP_YV && caps_q[card_supply_o - 3'd1])
    else $error("card supply granted wrongly");
  chk_prog_grant: assert property (
    prog_supply_o != SUP_OFF
    |-> prog_supply_o <= SUP_YV && caps_q[prog_supply_o - 3'd1])
    else $error("program supply granted wrongly");
  chk_run_enable: assert property (
    !clock_changed_o |-> card_clk_en_o)
    else $error("clock gated while flag clear");
  chk_busy_run: assert property (
    !socket_idle_i || card_access_i |-> ##1 !clock_changed_o)
    else $error("clock halted while socket busy");
  chk_slow_gap: assert property (
    clock_changed_o && card_clk_en_o && $past(clock_changed_o)
    |-> gap_q == 5'd15)
    else $error("slow clock pulse spacing wrong");
  chk_retest_src: assert property (
    retest_o |-> $past(tkn && write_i && address_i == OFS_FORCE
    && writedata_i[BIT_RETEST] && byteenable_i[1]))
    else $error("retest pulse without retest write");
endmodule : csp_socket_ctl_chk
bind csp_socket_ctl csp_socket_ctl_chk u_chk (
  .mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
  .address_i(address_i), .read_i(read_i), .write_i(write_i),
  .writedata_i(writedata_i), .byteenable_i(byteenable_i),
  .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
  .socket_idle_i(socket_idle_i), .card_access_i(card_access_i),
  .card_caps_i(card_caps_i), .card_supply_o(card_supply_o),
  .prog_supply_o(prog_supply_o), .card_clk_en_o(card_clk_en_o),
  .clock_changed_o(clock_changed_o), .retest_o(retest_o));
`default_nettype wire

// [card_socket_power_clock_ctl_tb.sv]
// Self-checking bench for the socket supply and clock block
// Assumes csp_pkg, the design, card model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module card_socket_power_clock_ctl_tb
  import csp_pkg::*;
;
  // ******
  // Signals
  // ******
  typedef struct packed {
    logic [31:0] wd; // Value written
    logic [31:0] rd; // Value read back
    logic [2:0]  c;  // Granted card supply
    logic [2:0]  p;  // Granted program supply
  } csp_row_s;
  logic        mclk_i, arst_n_i, rd, wr, hstop, busy, poke;
  logic [7:0]  addr;
  logic [31:0] wdat, rdat, rdata;
  logic [4:0]  caps, caps_c;
  logic [2:0]  csup, psup;
  logic        idle, acc, wreq, cen, chg, rtst, irq;
  int          fail_count, total_checks, n, k;
  csp_row_s    rows [8] = '{
    '{32'hFFFF_FFFF, 32'h0000_00F7, 3'h0, 3'h0},
    '{32'h0000_0021, 32'h0000_0021, 3'h2, 3'h1},
    '{32'h0000_0032, 32'h0000_0032, 3'h3, 3'h2},
    '{32'h0000_0043, 32'h0000_0043, 3'h4, 3'h3},
    '{32'h0000_0054, 32'h0000_0054, 3'h5, 3'h4},
    '{32'h0000_0015, 32'h0000_0015, 3'h0, 3'h5},
    '{32'h0000_0066, 32'h0000_0066, 3'h0, 3'h0},
    '{32'h0000_0000, 32'h0000_0000, 3'h0, 3'h0}};
  csp_card_model card (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .busy_i(busy),
    .poke_i(poke), .caps_i(caps), .idle_o(idle), .access_o(acc),
    .caps_o(caps_c));
  csp_socket_ctl dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .ce_i(1'b1),
    .address_i(addr), .read_i(rd), .write_i(wr), .writedata_i(wdat),
    .byteenable_i(4'hF), .readdata_o(rdata), .waitrequest_o(wreq),
    .socket_idle_i(idle), .host_clk_stop_i(hstop), .card_access_i(acc),
    .card_caps_i(caps_c), .card_supply_o(csup), .prog_supply_o(psup),
    .card_clk_en_o(cen), .clock_changed_o(chg), .retest_o(rtst),
    .irq_o(irq));
  // ******
  // Tasks
  // ******
  task automatic tick(input int m);
    repeat (m) @(posedge mclk_i);
  endtask : tick
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // One Avalon cycle, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    addr <= a;
    wdat <= d;
    wr   <= w;
    rd   <= ~w;
    @(posedge mclk_i);
    while (wreq !== 1'b0) begin
      @(posedge mclk_i);
    end
    rdat = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk_i);
  endtask : bus
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rdat, e);
  endtask : rchk
  task automatic note(input string s);
    $display("[DONE] %s", s);
  endtask : note
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  // ******
  // Clock, watchdog and sequence
  // ******
  initial begin
    mclk_i = 1'b0;
    forever #2.5 mclk_i = ~mclk_i;
  end
  initial begin
    #50us;
    fail_count++;
    wrap_up();
  end
  initial begin
    {arst_n_i, rd, wr, hstop, busy, poke} = '0;
    {addr, wdat, fail_count, total_checks} = '0;
    caps = 5'h1F;
    tick(10);
    check(csup, 32'h0);
    check({wreq, cen, chg, rtst, irq}, 32'h8);
    arst_n_i <= 1'b1;
    tick(2);
    rchk(OFS_SUPPLY_CTL, 32'h0);
    rchk(OFS_POWER_MGMT, 32'h0);
    note("reset");
    foreach (rows[i]) begin
      bus(1'b1, OFS_SUPPLY_CTL, rows[i].wd);
      rchk(OFS_SUPPLY_CTL, rows[i].rd);
      check(csup, rows[i].c);
      check(psup, rows[i].p);
    end
    note("codes");
    caps <= 5'h1D;
    bus(1'b1, OFS_SUPPLY_CTL, 32'h0000_0023);
    tick(2);
    check(csup, 32'h0);
    check(psup, 32'h3);
    caps <= 5'h1F;
    tick(3);
    check(csup, 32'h2);
    bus(1'b1, OFS_FORCE, 32'h0000_0400);
    tick(2);
    check(csup, 32'h0);
    bus(1'b1, OFS_FORCE, 32'h0000_4000);
    check(rtst, 32'h1);
    tick(2);
    check(csup, 32'h2);
    bus(1'b1, OFS_SUPPLY_CTL, 32'h0);
    note("supply");
    bus(1'b1, OFS_POWER_MGMT, 32'h0001_0000);
    tick(4);
    check(chg, 32'h0);
    hstop <= 1'b1;
    tick(4);
    check(chg, 32'h1);
    check(cen, 32'h0);
    rchk(OFS_POWER_MGMT, 32'h0101_0000);
    hstop <= 1'b0;
    tick(4);
    check(chg, 32'h0);
    bus(1'b1, OFS_SUPPLY_CTL, 32'h0000_0080);
    tick(4);
    check(chg, 32'h1);
    busy <= 1'b1;
    tick(4);
    check(chg, 32'h0);
    bus(1'b1, OFS_POWER_MGMT, 32'h0001_0001);
    busy <= 1'b0;
    k = 0;
    while (chg !== 1'b1 && k < 20) begin
      tick(1);
      k++;
    end
    n = 0;
    repeat (48) begin
      n += int'(cen === 1'b1);
      tick(1);
    end
    check(n, 32'h3);
    bus(1'b1, OFS_POWER_MGMT, 32'h0000_0001);
    tick(4);
    check(chg, 32'h0);
    check(cen, 32'h1);
    note("clock");
    rchk(OFS_IRQ_STATUS, 32'h0000_0002);
    bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0003);
    bus(1'b1, OFS_IRQ_MASK, 32'h0);
    poke <= 1'b1;
    tick(1);
    poke <= 1'b0;
    tick(3);
    check(irq, 32'h0);
    rchk(OFS_POWER_MGMT, 32'h0200_0001);
    rchk(OFS_POWER_MGMT, 32'h0000_0001);
    bus(1'b1, OFS_IRQ_MASK, 32'h0000_0003);
    tick(1);
    check(irq, 32'h1);
    bus(1'b1, OFS_IRQ_STATUS, 32'h0000_0001);
    tick(1);
    check(irq, 32'h0);
    poke <= 1'b1;
    tick(3);
    rchk(OFS_POWER_MGMT, 32'h0200_0001);
    poke <= 1'b0;
    rchk(OFS_POWER_MGMT, 32'h0200_0001);
    rchk(OFS_POWER_MGMT, 32'h0000_0001);
    bus(1'b1, 8'h44, 32'hFFFF_FFFF);
    rchk(8'h44, 32'h0);
    note("access");
    bus(1'b1, OFS_SUPPLY_CTL, 32'h0000_0021);
    arst_n_i <= 1'b0;
    tick(2);
    check(csup, 32'h0);
    arst_n_i <= 1'b1;
    tick(2);
    rchk(OFS_SUPPLY_CTL, 32'h0);
    note("reset again");
    wrap_up();
  end
endmodule : card_socket_power_clock_ctl_tb
`default_nettype wire
